// [rtl/wake_pkg.sv]
// Constants, types and state layout for the wake input block
package wake_pkg;

  // Register bus shape
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

  typedef struct packed {
    logic  wr;
    logic  rd;
    addr_t addr;
    data_t wdata;
  } bus_req_t;

  // Register offsets
  localparam addr_t ADDR_WAKE_CTRL = 3'h0;
  localparam addr_t ADDR_HW_CTRL   = 3'h1;
  localparam addr_t ADDR_BIAS_CTRL = 3'h2;
  localparam addr_t ADDR_STAT_A    = 3'h3;
  localparam addr_t ADDR_STAT_B    = 3'h4;
  localparam addr_t ADDR_TIMEOUT   = 3'h5;
  localparam addr_t ADDR_LEVEL     = 3'h6;

  // Field positions
  localparam int CTRL_PIN_EN_BIT  = 0;
  localparam int CTRL_VBAT_EN_BIT = 1;
  localparam int CTRL_TO_EN_BIT   = 2;
  localparam int HW_CONV_SEL_BIT  = 0;
  localparam int BIAS_LSB         = 0;
  localparam int STAT_PIN_BIT     = 0;
  localparam int STAT_VBAT_BIT    = 1;
  localparam int STAT_PFM_BIT     = 2;
  localparam int TO_FLAG_BIT      = 0;
  localparam int LEVEL_BIT        = 0;

  // Chip operating modes, supplied by the mode controller
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'b00,
    MODE_STOP     = 2'b01,
    MODE_SLEEP    = 2'b10,
    MODE_FAILSAFE = 2'b11
  } chip_mode_t;

  // Pin current source selection
  typedef enum logic [1:0] {
    BIAS_NONE = 2'b00,
    BIAS_DOWN = 2'b01,
    BIAS_UP   = 2'b10,
    BIAS_AUTO = 2'b11
  } bias_t;

  // Interrupt pulse sequencer
  typedef enum logic [1:0] {
    INT_IDLE  = 2'b00,
    INT_PULSE = 2'b01,
    INT_GAP   = 2'b10
  } int_state_t;

  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FILTER_TIME_NS = 16000;
  localparam int PULSE_TIME_NS  = 100000;
  localparam int GAP_TIME_NS    = 100000;
  localparam int FILTER_CYC     = FILTER_TIME_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYC_DEF  = PULSE_TIME_NS / CLK_PERIOD_NS;
  localparam int GAP_CYC_DEF    = GAP_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 16;

  // Entire state of the block
  typedef struct packed {
    int_state_t       ist;
    logic [CNT_W-1:0] icnt;
    logic             pend;
    logic             int_n;
    logic             pin_en;
    logic             vbat_en;
    logic             to_en;
    logic             conv_sel;
    bias_t            bias;
    data_t            stat_a;
    data_t            stat_b;
    logic             to_flag;
    data_t            snap_a;
    data_t            snap_b;
    logic             snap_to;
    logic             primed;
    logic             filt_lvl;
    logic [CNT_W-1:0] fcnt;
    logic             wake_req;
    logic             restart_req;
    logic             pull_up;
    logic             pull_down;
    logic             conv_by_pin;
    logic             conv_pwm;
    data_t            rdata;
  } core_state_t;

  localparam core_state_t STATE_RST = '{
    ist: INT_IDLE, int_n: 1'b1, bias: BIAS_NONE, default: '0};

endpackage

// [rtl/wake_input_interrupt_logic.sv]
// Wake input filtering, wake status flags and interrupt pulse output
//
// Operation
// - Both pin edges count as wake events
// - Normal/Stop: pin event raises interrupt
// - Sleep/Fail-Safe: pin event wakes device
// - Enable bit gates wake from Sleep
// - Interrupt only after wake filter time
// - Fail-Safe: any edge requests Restart always
// - Pin wake recorded in pin wake flag
// - Live pin level readable in status
// - Option bit: pin level picks PFM/PWM
// - Converter selection uses unfiltered level
// - Converter option still allows Sleep wake
// - Two-bit bias field selects current source
// - Auto bias follows detected pin level
// - Interrupt low for pulse width, released
// - Output high at least gap time
// - Interrupt never changes operating mode
// - Timeout status flag and timeout interrupt gated by its enable
// - Battery crossing, PFM-to-PWM raise interrupt
// - Pin, battery and timeout need enables; PFM, external, Stop entry do not; level never
// - Stop entry with flags set interrupts
// - Readable status refreshed at pulse start
// - Flags held until software clears them
//
// Decided for this implementation: the register offsets and the strobed register port.
module wake_input_interrupt_logic #(
  parameter int unsigned PULSE_CYC = wake_pkg::PULSE_CYC_DEF,
  parameter int unsigned GAP_CYC   = wake_pkg::GAP_CYC_DEF
) (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  // Register port
  input  wire wake_pkg::bus_req_t          i_bus,
  output logic [wake_pkg::DATA_W-1:0]      o_rdata,
  // Pin and chip context
  input  wire logic                        i_wake_sense_pin,
  input  wire wake_pkg::chip_mode_t        i_mode,
  input  wire logic                        i_stop_entry,
  // Other event sources
  input  wire logic                        i_vbat_cross,
  input  wire logic                        i_pfm_to_pwm,
  input  wire logic                        i_bus_timeout,
  input  wire logic [wake_pkg::DATA_W-1:0] i_ext_wake,
  // Results
  output logic                             o_interrupt_out_n,
  output logic                             o_wake_req,
  output logic                             o_restart_req,
  output logic                             o_pull_up_en,
  output logic                             o_pull_down_en,
  output logic                             o_conv_by_pin,
  output logic                             o_conv_pwm
);
  import wake_pkg::*;

  core_state_t s_q;
  core_state_t s_d;

  // Clears only flags the host has already seen in its snapshot
  function automatic data_t ack(input data_t flags,
                                input data_t seen,
                                input data_t mask);
    ack = flags & ~(seen & mask);
  endfunction

  logic  wr_hit;
  logic  pin_ev;
  logic  int_mode;
  data_t new_a;
  data_t clr_a;
  data_t clr_b;
  data_t clr_to;
  logic  to_ev;
  logic  notify;

  // Modes in which events are reported by pulse
  assign int_mode = (i_mode == MODE_NORMAL) ||
                    (i_mode == MODE_STOP);

  // Next state of the whole block, one copy of the state struct
  always_comb begin
    s_d         = s_q;
    s_d.wake_req    = 1'b0;
    s_d.restart_req = 1'b0;
    pin_ev      = 1'b0;
    new_a       = '0;
    clr_a       = '0;
    clr_b       = '0;
    clr_to      = '0;
    to_ev       = 1'b0;
    notify      = 1'b0;
    wr_hit      = i_bus.wr;

    // Edge filter: new level must hold for the filter time
    if (!s_q.primed) begin
      // Adopt the pin level after reset without an event
      s_d.primed   = 1'b1;
      s_d.filt_lvl = i_wake_sense_pin;
      s_d.fcnt     = '0;
    end else if (i_wake_sense_pin == s_q.filt_lvl) begin
      s_d.fcnt = '0;
    end else if (s_q.fcnt == CNT_W'(FILTER_CYC - 1)) begin
      s_d.filt_lvl = i_wake_sense_pin;
      s_d.fcnt     = '0;
      pin_ev       = 1'b1;
    end else begin
      s_d.fcnt = s_q.fcnt + CNT_W'(1);
    end

    // Register writes
    if (wr_hit) begin
      unique case (i_bus.addr)
        ADDR_WAKE_CTRL: begin
          s_d.pin_en  = i_bus.wdata[CTRL_PIN_EN_BIT];
          s_d.vbat_en = i_bus.wdata[CTRL_VBAT_EN_BIT];
          s_d.to_en   = i_bus.wdata[CTRL_TO_EN_BIT];
        end
        ADDR_HW_CTRL: begin
          s_d.conv_sel = i_bus.wdata[HW_CONV_SEL_BIT];
        end
        ADDR_BIAS_CTRL: begin
          s_d.bias = bias_t'(i_bus.wdata[BIAS_LSB +: 2]);
        end
        ADDR_STAT_A: clr_a = i_bus.wdata;
        ADDR_STAT_B: clr_b = i_bus.wdata;
        ADDR_TIMEOUT: clr_to = i_bus.wdata;
        default: ;
      endcase
    end

    // Pin event handling by mode
    if (pin_ev) begin
      unique case (i_mode)
        MODE_NORMAL, MODE_STOP: begin
          if (s_q.pin_en) begin
            new_a[STAT_PIN_BIT] = 1'b1;
          end
        end
        MODE_SLEEP: begin
          // Converter option does not block this path
          if (s_q.pin_en) begin
            new_a[STAT_PIN_BIT] = 1'b1;
            s_d.wake_req = 1'b1;
          end
        end
        MODE_FAILSAFE: begin
          // Enable bit is ignored here on purpose
          new_a[STAT_PIN_BIT] = 1'b1;
          s_d.restart_req = 1'b1;
        end
      endcase
    end

    // Other sources: battery and timeout gated by their enables, PFM-to-PWM by Stop mode
    if (i_vbat_cross && s_q.vbat_en) begin
      new_a[STAT_VBAT_BIT] = 1'b1;
    end
    if (i_pfm_to_pwm && (i_mode == MODE_STOP)) begin
      new_a[STAT_PFM_BIT] = 1'b1;
    end
    to_ev = i_bus_timeout && s_q.to_en;

    // Sticky flags: a new event beats a same-cycle clear
    s_d.stat_a  = ack(s_q.stat_a, s_q.snap_a, clr_a)
                  | new_a;
    s_d.stat_b  = ack(s_q.stat_b, s_q.snap_b, clr_b)
                  | i_ext_wake;
    s_d.to_flag = (s_q.to_flag & ~(s_q.snap_to & clr_to[TO_FLAG_BIT]))
                  | to_ev;
    s_d.snap_a  = s_q.snap_a & ~clr_a;
    s_d.snap_b  = s_q.snap_b & ~clr_b;
    s_d.snap_to = s_q.snap_to & ~clr_to[TO_FLAG_BIT];

    // Anything new in a reporting mode asks for a pulse
    notify = int_mode &&
             ((|new_a) || (|i_ext_wake) || to_ev);
    if (i_stop_entry &&
        ((|s_d.stat_a) || (|s_d.stat_b))) begin
      notify = 1'b1;
    end
    // Held until a pulse may start, never dropped
    s_d.pend = s_q.pend | notify;

    // Pulse sequencer; it has no mode output at all
    unique case (s_q.ist)
      INT_IDLE: begin
        if (s_q.pend && int_mode) begin
          s_d.ist   = INT_PULSE;
          s_d.int_n = 1'b0;
          s_d.icnt  = CNT_W'(PULSE_CYC - 1);
          s_d.pend  = 1'b0;
          // Falling edge: host view takes the latest flags
          s_d.snap_a  = s_d.stat_a;
          s_d.snap_b  = s_d.stat_b;
          s_d.snap_to = s_d.to_flag;
        end
      end
      INT_PULSE: begin
        if (s_q.icnt == '0) begin
          s_d.ist   = INT_GAP;
          s_d.int_n = 1'b1;
          s_d.icnt  = CNT_W'(GAP_CYC - 1);
        end else begin
          s_d.icnt = s_q.icnt - CNT_W'(1);
        end
      end
      INT_GAP: begin
        // High time is guaranteed before the next pulse
        if (s_q.icnt == '0) begin
          s_d.ist = INT_IDLE;
        end else begin
          s_d.icnt = s_q.icnt - CNT_W'(1);
        end
      end
      default: begin
        s_d.ist   = INT_IDLE;
        s_d.int_n = 1'b1;
      end
    endcase

    // Bias outputs; auto follows the detected level
    unique case (s_q.bias)
      BIAS_NONE: begin
        s_d.pull_up   = 1'b0;
        s_d.pull_down = 1'b0;
      end
      BIAS_DOWN: begin
        s_d.pull_up   = 1'b0;
        s_d.pull_down = 1'b1;
      end
      BIAS_UP: begin
        s_d.pull_up   = 1'b1;
        s_d.pull_down = 1'b0;
      end
      BIAS_AUTO: begin
        s_d.pull_up   = i_wake_sense_pin;
        s_d.pull_down = ~i_wake_sense_pin;
      end
    endcase

    // Converter select: raw level, filter bypassed
    s_d.conv_by_pin = s_q.conv_sel &&
                      (i_mode == MODE_STOP);
    s_d.conv_pwm    = s_d.conv_by_pin &&
                      i_wake_sense_pin;

    // Read data, valid only the cycle after the strobe
    s_d.rdata = '0;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_WAKE_CTRL: begin
          s_d.rdata[CTRL_PIN_EN_BIT]  = s_q.pin_en;
          s_d.rdata[CTRL_VBAT_EN_BIT] = s_q.vbat_en;
          s_d.rdata[CTRL_TO_EN_BIT]   = s_q.to_en;
        end
        ADDR_HW_CTRL: begin
          s_d.rdata[HW_CONV_SEL_BIT] = s_q.conv_sel;
        end
        ADDR_BIAS_CTRL: s_d.rdata[BIAS_LSB +: 2] = s_q.bias;
        ADDR_STAT_A: s_d.rdata = s_q.snap_a;
        ADDR_STAT_B: s_d.rdata = s_q.snap_b;
        ADDR_TIMEOUT: s_d.rdata[TO_FLAG_BIT] = s_q.snap_to;
        ADDR_LEVEL: begin
          // Live level, never a source of interrupts
          s_d.rdata[LEVEL_BIT] = i_wake_sense_pin;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata           = s_q.rdata;
  assign o_interrupt_out_n = s_q.int_n;
  assign o_wake_req        = s_q.wake_req;
  assign o_restart_req     = s_q.restart_req;
  assign o_pull_up_en      = s_q.pull_up;
  assign o_pull_down_en    = s_q.pull_down;
  assign o_conv_by_pin     = s_q.conv_by_pin;
  assign o_conv_pwm        = s_q.conv_pwm;

endmodule

// [testbench/wake_input_interrupt_logic_checker.sv]
// Port-level checks for the wake input and interrupt block
module wake_input_interrupt_logic_checker #(
  parameter int unsigned PULSE_CYC = 20,
  parameter int unsigned GAP_CYC   = 20
) (
  // Clock, reset and stimulus
  input wire logic                          i_clk,
  input wire logic                          i_reset,
  input wire wake_pkg::bus_req_t            i_bus,
  input wire logic                          i_wake_sense_pin,
  input wire wake_pkg::chip_mode_t          i_mode,
  // Results
  input wire logic [wake_pkg::DATA_W-1:0]   o_rdata,
  input wire logic                          o_interrupt_out_n,
  input wire logic                          o_wake_req,
  input wire logic                          o_restart_req,
  input wire logic                          o_pull_up_en,
  input wire logic                          o_pull_down_en,
  input wire logic                          o_conv_by_pin,
  input wire logic                          o_conv_pwm
);
  timeunit 1ns;
  timeprecision 1ns;
  import wake_pkg::*;
  logic [15:0] low_q;
  logic [15:0] high_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // Run lengths of the line; high count saturates so long idles stay legal
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      low_q  <= '0;
      high_q <= 16'(GAP_CYC);
    end else begin
      low_q  <= o_interrupt_out_n ? 16'h0000 : low_q + 16'h0001;
      high_q <= !o_interrupt_out_n ? 16'h0000 :
                (&high_q) ? high_q : high_q + 16'h0001;
    end
  end

  sequence s_pulse_start;
    $fell(o_interrupt_out_n);
  endsequence
  sequence s_pulse_end;
    $rose(o_interrupt_out_n) && !$past(i_reset);
  endsequence

  property p_width;
    s_pulse_end |-> low_q == 16'(PULSE_CYC);
  endproperty
  a_width: assert property (p_width)
    else $error("interrupt pulse width wrong");
  property p_gap;
    s_pulse_start |-> high_q >= 16'(GAP_CYC);
  endproperty
  a_gap: assert property (p_gap)
    else $error("interrupt gap too short");
  property p_pulse_mode;
    s_pulse_start |-> $past(i_mode) inside {MODE_NORMAL, MODE_STOP};
  endproperty
  a_pulse_mode: assert property (p_pulse_mode)
    else $error("interrupt pulse outside normal or stop");
  property p_wake;
    o_wake_req |-> $past(i_mode) == MODE_SLEEP;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request outside sleep");
  property p_restart;
    o_restart_req |-> $past(i_mode) == MODE_FAILSAFE;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart request outside fail-safe");
  property p_conv_mode;
    o_conv_by_pin |-> $past(i_mode) == MODE_STOP;
  endproperty
  a_conv_mode: assert property (p_conv_mode)
    else $error("converter select outside stop");
  property p_conv_raw;
    o_conv_by_pin |-> o_conv_pwm == $past(i_wake_sense_pin);
  endproperty
  a_conv_raw: assert property (p_conv_raw)
    else $error("converter mode not following raw pin");
  property p_bias;
    o_pull_up_en |-> !o_pull_down_en;
  endproperty
  a_bias: assert property (p_bias)
    else $error("pull-up and pull-down both on");
  property p_level;
    $past(i_bus.rd) && $past(i_bus.addr) == ADDR_LEVEL &&
      $past(i_wake_sense_pin) == $past(i_wake_sense_pin, 2)
      |-> o_rdata[LEVEL_BIT] == $past(i_wake_sense_pin);
  endproperty
  a_level: assert property (p_level)
    else $error("level read wrong");
  property p_no_mode;
    s_pulse_start |-> !o_wake_req && !o_restart_req;
  endproperty
  a_no_mode: assert property (p_no_mode)
    else $error("interrupt pulse came with a mode request");
endmodule

bind wake_input_interrupt_logic wake_input_interrupt_logic_checker #(
  .PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) i_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus),
  .i_wake_sense_pin(i_wake_sense_pin), .i_mode(i_mode),
  .o_rdata(o_rdata), .o_interrupt_out_n(o_interrupt_out_n),
  .o_wake_req(o_wake_req), .o_restart_req(o_restart_req),
  .o_pull_up_en(o_pull_up_en), .o_pull_down_en(o_pull_down_en),
  .o_conv_by_pin(o_conv_by_pin), .o_conv_pwm(o_conv_pwm));

// [testbench/wake_host_model.sv]
// Host side: watches the interrupt line and tallies pulses
module wake_host_model (
  // Clock and watched line
  input  wire logic i_clk,
  input  wire logic i_interrupt_out_n,
  // Pulse tally
  output int        o_pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q  = 1'b1;
  int   count_q = 0;

  // Host reacts to the falling edge only; status is fetched afterwards
  always @(posedge i_clk) begin
    if (last_q && !i_interrupt_out_n) count_q <= count_q + 1;
    last_q <= i_interrupt_out_n;
  end

  // Single driver for the tally
  assign o_pulses = count_q;
endmodule

// [testbench/test_wake_input_interrupt_logic.sv]
// Self-checking bench for the wake input and interrupt block
module test_wake_input_interrupt_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import wake_pkg::*;
  localparam int P = 20;
  localparam int G = 20;
  localparam int SETTLE = P + G + 10;
  logic clk = 1'b0, rst = 1'b1, pin = 1'b0;
  logic stp = 1'b0, vb = 1'b0, pp = 1'b0, to = 1'b0;
  data_t ext = '0;
  bus_req_t bus = '0;
  chip_mode_t mode = MODE_NORMAL;
  data_t rdata;
  logic int_n, wreq, rreq, pu, pd, cbp, cpwm;
  int pulses, failures = 0, n_checks = 0, nw = 0, nr = 0;

  always #5 clk = ~clk;
  // One-cycle requests are tallied as they happen
  always @(posedge clk) begin
    nw <= nw + int'(wreq);
    nr <= nr + int'(rreq);
  end

  wake_input_interrupt_logic #(.PULSE_CYC(P), .GAP_CYC(G))
    i_wake_input_interrupt_logic (
    .i_clk(clk), .i_reset(rst), .i_bus(bus), .o_rdata(rdata),
    .i_wake_sense_pin(pin), .i_mode(mode), .i_stop_entry(stp),
    .i_vbat_cross(vb), .i_pfm_to_pwm(pp), .i_bus_timeout(to),
    .i_ext_wake(ext), .o_interrupt_out_n(int_n), .o_wake_req(wreq),
    .o_restart_req(rreq), .o_pull_up_en(pu), .o_pull_down_en(pd),
    .o_conv_by_pin(cbp), .o_conv_pwm(cpwm));
  wake_host_model i_wake_host_model (
    .i_clk(clk), .i_interrupt_out_n(int_n), .o_pulses(pulses));

  task automatic chk(input data_t seen, input data_t exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Wait, then step past the edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input addr_t a, input data_t d);
    @(posedge clk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input addr_t a, input data_t e);
    @(posedge clk);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(rdata, e);
  endtask
  // Strobe events for one cycle, then let pulse and gap run out
  task automatic fire(input logic [3:0] ev, input int exp);
    int p0;
    p0 = pulses;
    @(posedge clk);
    {stp, vb, pp, to} <= ev;
    @(posedge clk);
    {stp, vb, pp, to} <= 4'h0;
    wt(SETTLE);
    chk(8'(pulses - p0), 8'(exp));
  endtask
  // Move the pin and hold it well past the wake filter
  task automatic flip(input logic v);
    @(posedge clk);
    pin <= v;
    wt(FILTER_CYC + SETTLE);
  endtask
  task automatic setm(input chip_mode_t m);
    @(posedge clk);
    mode <= m;
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    int p0;
    int w0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(addr_t'(a), 8'h00);
    end
    for (int b = 0; b < 4; b++) begin
      wr(ADDR_BIAS_CTRL, 8'(b));
      wt(2);
      chk({6'h00, pu, pd}, 8'(b == 3 ? 1 : b));
    end
    // Pin event in normal mode must wait out the filter
    wr(ADDR_WAKE_CTRL, 8'h05);
    @(posedge clk);
    pin <= 1'b1;
    wt(FILTER_CYC - 10);
    chk({7'h00, int_n}, 8'h01);
    wt(15);
    chk({7'h00, int_n}, 8'h00);
    chk({6'h00, pu, pd}, 8'h02);
    wt(SETTLE);
    rd(ADDR_STAT_A, 8'h01);
    rd(ADDR_LEVEL, 8'h01);
    wr(ADDR_STAT_A, 8'h01);
    rd(ADDR_STAT_A, 8'h00);
    // Disabled source stays silent; enabled one pulses
    fire(4'b0100, 0);
    wr(ADDR_WAKE_CTRL, 8'h07);
    fire(4'b0100, 1);
    // Timeout during a live pulse is held for the next one
    @(posedge clk);
    vb <= 1'b1;
    @(posedge clk);
    vb <= 1'b0;
    wt(3);
    fire(4'b0001, 1);
    rd(ADDR_TIMEOUT, 8'h01);
    wr(ADDR_TIMEOUT, 8'h01);
    @(posedge clk);
    ext <= 8'h10;
    @(posedge clk);
    ext <= 8'h00;
    wt(SETTLE);
    rd(ADDR_STAT_B, 8'h10);
    wr(ADDR_STAT_B, 8'h10);
    // Stop entry with a flag still set, then with all clear
    setm(MODE_STOP);
    fire(4'b1000, 1);
    fire(4'b0010, 1);
    rd(ADDR_STAT_A, 8'h06);
    wr(ADDR_STAT_A, 8'h06);
    fire(4'b1000, 0);
    // Pin picks the converter mode with no filter delay
    wr(ADDR_HW_CTRL, 8'h01);
    wt(2);
    chk({6'h00, cbp, cpwm}, 8'h03);
    @(posedge clk);
    pin <= 1'b0;
    wt(2);
    chk({6'h00, cbp, cpwm}, 8'h02);
    wt(FILTER_CYC + SETTLE);
    rd(ADDR_STAT_A, 8'h01);
    wr(ADDR_STAT_A, 8'h01);
    // Sleep: wake instead of interrupt, gated by the enable
    setm(MODE_SLEEP);
    p0 = pulses;
    w0 = nw;
    flip(1'b1);
    chk(8'(nw - w0), 8'h01);
    chk(8'(pulses - p0), 8'h00);
    wr(ADDR_WAKE_CTRL, 8'h06);
    flip(1'b0);
    chk(8'(nw - w0), 8'h01);
    setm(MODE_FAILSAFE);
    w0 = nr;
    flip(1'b1);
    chk(8'(nr - w0), 8'h01);
    wrap_up();
  end

  // Run needs about 8700 cycles; the limit leaves ample slack
  initial begin
    wt(40000);
    failures++;
    wrap_up();
  end
endmodule
